/* gpcb_defs.svh */
/*
  Offsets, field positions, masks and reset values of the pin configuration bank.
  Assumes a 32-bit APB bus; the offsets are register indices and the byte address is four times
  the index.
*/
`ifndef GPCB_DEFS_SVH
`define GPCB_DEFS_SVH

`define GPCB_NUM_PINS 8
`define GPCB_ADDR_W 8
`define GPCB_CFG_W 8

`define GPCB_IDX_PIN_1_6 8'h29
`define GPCB_IDX_PIN_1_7 8'h2A
`define GPCB_IDX_PIN_2_0 8'h2B
`define GPCB_IDX_PIN_2_1 8'h2C
`define GPCB_IDX_PIN_2_2 8'h2D
`define GPCB_IDX_RESERVED 8'h2E
`define GPCB_IDX_PIN_2_4 8'h2F
`define GPCB_IDX_PIN_2_5 8'h30
`define GPCB_IDX_PIN_2_6 8'h31

`define GPCB_BIT_DIR 0
`define GPCB_BIT_POL 1
`define GPCB_BIT_ALT 2
`define GPCB_BIT_ALT_HI 3
`define GPCB_BIT_OTYPE 7

`define GPCB_CFG_RESET 8'h01
`define GPCB_MASK_ONE_BIT 8'h87
`define GPCB_MASK_TWO_BIT 8'h8F
`define GPCB_MASK_NO_ALT 8'h83

`define GPCB_PIN_NONE 4'hF

`endif

/* gpcb_monitor.sv */
/*
  Checker of the pin configuration bank, shadowing the configuration from APB writes.
  Assumes it is bound to gpcb_top.
*/
`timescale 1ns/1ps
module gpcb_monitor (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PSLVERR_O,
  input wire logic [7:0] PAD_IN_I,
  input wire logic [7:0] PAD_OUT_O,
  input wire logic [7:0] PAD_OE_O,
  input wire logic [7:0] GPIO_OUT_I,
  input wire logic FLOPPY_MOTOR_SELECT_1_N_I,
  input wire logic MUSIC_SERIAL_TRANSMIT_I,
  input wire logic MUSIC_SERIAL_RECEIVE_O,
  input wire logic STICK2_X_AXIS_TIMING_O,
  input wire logic [1:0] EDGE_EVENT_O,
  input wire logic [1:0] EDGE_LEVEL_O
);
  logic [7:0] c_q [8];
  logic [2:0] idx;
  logic [7:0] msk;
  logic acc;
  assign acc = PSEL_I && PENABLE_I && PADDR_I[1:0] == 2'h0 && PADDR_I >= 8'hA4
    && PADDR_I <= 8'hC4 && PADDR_I != 8'hB8;
  assign idx = (PADDR_I < 8'hB8) ? 3'((PADDR_I - 8'hA4) >> 2) : 3'((PADDR_I - 8'hA8) >> 2);
  assign msk = (idx == 3'h3 || idx == 3'h4) ? 8'h8F : (idx == 3'h5) ? 8'h83 : 8'h87;
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < 8; i++) begin
        c_q[i] <= 8'h01;
      end
    end else if (acc && PWRITE_I && PSTRB_I[0]) begin
      c_q[idx] <= PWDATA_I[7:0] & msk;
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_armed;
    (c_q[3][3:2] == 2'h2) [*4];
  endsequence
  a_read_back: assert property (acc && !PWRITE_I |-> PRDATA_O == {24'h000000, c_q[idx]})
    else $error("read data differs from shadow");
  a_rsvd_zero: assert property (PSEL_I && PENABLE_I && PADDR_I == 8'hB8 |->
    PRDATA_O == 32'h00000000 && !PSLVERR_O) else $error("reserved word misbehaves");
  a_dir_input: assert property ($past(c_q[5][0]) |-> !PAD_OE_O[5])
    else $error("input pin drives");
  a_push_pull: assert property ($past(!c_q[5][0] && !c_q[5][7]) |-> PAD_OE_O[5] &&
    PAD_OUT_O[5] == $past(GPIO_OUT_I[5] ^ c_q[5][1])) else $error("output drive wrong");
  a_open_drain: assert property ($past(c_q[5][7]) |-> !PAD_OUT_O[5])
    else $error("open drain drives high");
  a_stick_x: assert property ($past(NRST_I) |-> STICK2_X_AXIS_TIMING_O ==
    ($past(c_q[0][2]) & $past(PAD_IN_I[0] ^ c_q[0][1]))) else $error("stick x wrong");
  a_music_rx: assert property ($past(NRST_I) |-> MUSIC_SERIAL_RECEIVE_O ==
    (!$past(c_q[6][2]) | $past(PAD_IN_I[6] ^ c_q[6][1]))) else $error("receive wrong");
  a_music_tx: assert property ($past(c_q[7][2] && !c_q[7][0] && !c_q[7][7]) |->
    PAD_OE_O[7] && PAD_OUT_O[7] == $past(MUSIC_SERIAL_TRANSMIT_I ^ c_q[7][1]))
    else $error("tx wrong");
  a_motor_sel: assert property ($past(c_q[4][3:0] == 4'hC && !c_q[4][7]) |->
    PAD_OUT_O[4] == $past(FLOPPY_MOTOR_SELECT_1_N_I)) else $error("motor select wrong");
  a_edge_pulse: assert property (s_armed ##0 $changed(EDGE_LEVEL_O[0]) |->
    ##[0:1] EDGE_EVENT_O[0]) else $error("edge gave no event");
endmodule // gpcb_monitor

/* gpcb_pad_model.sv */
/*
  Pad model: resolves each pad from the bank's drive and the far side's own level.
  Assumes the far side changes its level just after a rising clock edge.
*/
`timescale 1ns/1ps
module gpcb_pad_model (
  input wire logic [7:0] oe_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pad_o
);
  assign pad_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule // gpcb_pad_model

/* gpcb_pkg.sv */
/*
  Types of the pin configuration bank.
  Assumes nothing beyond the constants header.
*/
package gpcb_pkg;

  typedef enum {
    GPCB_FN_GPIO,
    GPCB_FN_STICK_X,
    GPCB_FN_STICK_Y,
    GPCB_FN_KBC7,
    GPCB_FN_KBC6,
    GPCB_FN_KBC2,
    GPCB_FN_DRIVE_SEL,
    GPCB_FN_MOTOR_SEL,
    GPCB_FN_EDGE0,
    GPCB_FN_EDGE1,
    GPCB_FN_MIDI_RX,
    GPCB_FN_MIDI_TX
  } gpcb_func_t;

  typedef logic [7:0] gpcb_cfg_t;

endpackage

/* gpcb_top.sv */
/*
  Configuration bank for eight general purpose pins (1.6, 1.7, 2.0, 2.1, 2.2, 2.4, 2.5, 2.6),
  reached over APB, with the pad steering that the configuration selects.
  Assumes the pad inputs and all function inputs are synchronous to CLOCK_I, the GPIO data
  registers sit outside, and NRST_I is the standby supply power-on reset.
*/
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "gpcb_defs.svh"

module gpcb_top
  import gpcb_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [`GPCB_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [`GPCB_NUM_PINS-1:0] PAD_IN_I,
  output logic [`GPCB_NUM_PINS-1:0] PAD_OUT_O,
  output logic [`GPCB_NUM_PINS-1:0] PAD_OE_O,
  input wire logic [`GPCB_NUM_PINS-1:0] GPIO_OUT_I,
  output logic [`GPCB_NUM_PINS-1:0] GPIO_IN_O,
  input wire logic KBC_PORT_LINE_7_I,
  input wire logic KBC_PORT_LINE_6_I,
  input wire logic KBC_PORT_LINE_2_I,
  output logic KBC_PORT_LINE_7_O,
  output logic KBC_PORT_LINE_6_O,
  output logic KBC_PORT_LINE_2_O,
  input wire logic FLOPPY_DRIVE_SELECT_1_N_I,
  input wire logic FLOPPY_MOTOR_SELECT_1_N_I,
  input wire logic MUSIC_SERIAL_TRANSMIT_I,
  output logic MUSIC_SERIAL_RECEIVE_O,
  output logic STICK2_X_AXIS_TIMING_O,
  output logic STICK2_Y_AXIS_TIMING_O,
  output logic [1:0] EDGE_EVENT_O,
  output logic [1:0] EDGE_LEVEL_O
);

  // Maps a byte address onto a pin slot, or none for unmapped and reserved words.
  function automatic logic [3:0] addr_to_pin(input logic [`GPCB_ADDR_W-1:0] addr);
    logic [3:0] pin;
    pin = `GPCB_PIN_NONE;
    if (addr[1:0] == 2'b00) begin
      unique case (addr[`GPCB_ADDR_W-1:2])
        6'(`GPCB_IDX_PIN_1_6): pin = 4'h0;
        6'(`GPCB_IDX_PIN_1_7): pin = 4'h1;
        6'(`GPCB_IDX_PIN_2_0): pin = 4'h2;
        6'(`GPCB_IDX_PIN_2_1): pin = 4'h3;
        6'(`GPCB_IDX_PIN_2_2): pin = 4'h4;
        6'(`GPCB_IDX_PIN_2_4): pin = 4'h5;
        6'(`GPCB_IDX_PIN_2_5): pin = 4'h6;
        6'(`GPCB_IDX_PIN_2_6): pin = 4'h7;
        default: pin = `GPCB_PIN_NONE;
      endcase
    end
    return pin;
  endfunction

  // True for the reserved word that reads zero and takes no writes.
  function automatic logic addr_is_reserved(input logic [`GPCB_ADDR_W-1:0] addr);
    return (addr == `GPCB_ADDR_W'({`GPCB_IDX_RESERVED, 2'b00}));
  endfunction

  // Writable bits of each pin slot.
  function automatic gpcb_cfg_t pin_mask(input logic [3:0] pin);
    gpcb_cfg_t mask;
    mask = `GPCB_MASK_ONE_BIT;
    unique case (pin)
      4'h3, 4'h4: mask = `GPCB_MASK_TWO_BIT;
      4'h5: mask = `GPCB_MASK_NO_ALT;
      default: mask = `GPCB_MASK_ONE_BIT;
    endcase
    return mask;
  endfunction

  // Decodes the function a pin carries from its configuration.
  function automatic gpcb_func_t pin_func(input logic [3:0] pin, input gpcb_cfg_t cfg);
    gpcb_func_t fn;
    logic alt;
    logic [1:0] sel;
    fn = GPCB_FN_GPIO;
    alt = cfg[`GPCB_BIT_ALT];
    sel = cfg[`GPCB_BIT_ALT_HI:`GPCB_BIT_ALT];
    unique case (pin)
      4'h0: fn = alt ? GPCB_FN_STICK_X : GPCB_FN_GPIO;
      4'h1: fn = alt ? GPCB_FN_STICK_Y : GPCB_FN_GPIO;
      4'h2: fn = alt ? GPCB_FN_KBC7 : GPCB_FN_GPIO;
      4'h3: begin
        unique case (sel)
          2'b11: fn = GPCB_FN_DRIVE_SEL;
          2'b10: fn = GPCB_FN_EDGE0;
          2'b01: fn = GPCB_FN_KBC6;
          2'b00: fn = GPCB_FN_GPIO;
        endcase
      end
      4'h4: begin
        unique case (sel)
          2'b11: fn = GPCB_FN_MOTOR_SEL;
          2'b10: fn = GPCB_FN_EDGE1;
          2'b01: fn = GPCB_FN_KBC2;
          2'b00: fn = GPCB_FN_GPIO;
        endcase
      end
      4'h6: fn = alt ? GPCB_FN_MIDI_RX : GPCB_FN_GPIO;
      4'h7: fn = alt ? GPCB_FN_MIDI_TX : GPCB_FN_GPIO;
      default: fn = GPCB_FN_GPIO;
    endcase
    return fn;
  endfunction

  // True for functions that only take the pin as an input.
  function automatic logic func_is_input(input gpcb_func_t fn);
    return (fn == GPCB_FN_STICK_X) || (fn == GPCB_FN_STICK_Y) || (fn == GPCB_FN_EDGE0) ||
           (fn == GPCB_FN_EDGE1) || (fn == GPCB_FN_MIDI_RX);
  endfunction

  gpcb_cfg_t cfg_q [`GPCB_NUM_PINS];
  gpcb_func_t func [`GPCB_NUM_PINS];
  logic [`GPCB_NUM_PINS-1:0] in_val;
  logic [`GPCB_NUM_PINS-1:0] out_src;
  logic [`GPCB_NUM_PINS-1:0] drv_val;
  logic [`GPCB_NUM_PINS-1:0] drv_en;
  logic [`GPCB_NUM_PINS-1:0] pad_out_d;
  logic [`GPCB_NUM_PINS-1:0] pad_oe_d;
  logic [`GPCB_NUM_PINS-1:0] pad_out_q;
  logic [`GPCB_NUM_PINS-1:0] pad_oe_q;
  logic [`GPCB_NUM_PINS-1:0] gpio_in_q;
  logic setup;
  logic access;
  logic [3:0] sel_pin;
  logic sel_rsvd;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic slverr_d;
  logic slverr_q;
  logic kbc7_q;
  logic kbc6_q;
  logic kbc2_q;
  logic midi_rx_q;
  logic stick_x_q;
  logic stick_y_q;
  logic [1:0] edge_in;
  logic [1:0] edge_sel;
  logic [1:0] edge_lvl_q;
  logic [1:0] edge_evt_q;
  logic [1:0] edge_armed_q;

  assign setup = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I;
  assign sel_pin = addr_to_pin(PADDR_I);
  assign sel_rsvd = addr_is_reserved(PADDR_I);

  // Register read data and error are prepared in the setup cycle.
  always_comb begin
    rdata_d = 32'h0000_0000;
    slverr_d = 1'b0;
    if (sel_pin != `GPCB_PIN_NONE) begin
      rdata_d = {24'h00_0000, cfg_q[sel_pin[2:0]] & pin_mask(sel_pin)};
    end else if (sel_rsvd) begin
      rdata_d = 32'h0000_0000;
      slverr_d = 1'b0;
    end else begin
      slverr_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup) begin
      rdata_q <= PWRITE_I ? 32'h0000_0000 : rdata_d;
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      slverr_q <= 1'b0;
    end else if (setup) begin
      slverr_q <= slverr_d;
    end
  end

  assign PREADY_O = 1'b1;
  assign PRDATA_O = rdata_q;
  assign PSLVERR_O = access & slverr_q;

  // Per-pin configuration storage and pad steering.
  genvar gi;
  generate
    for (gi = 0; gi < `GPCB_NUM_PINS; gi++) begin : g_pin
      always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          cfg_q[gi] <= `GPCB_CFG_RESET;
        end else if (access && PWRITE_I && PSTRB_I[0] && sel_pin == 4'(gi)) begin
          cfg_q[gi] <= PWDATA_I[7:0] & pin_mask(4'(gi));
        end
      end

      assign func[gi] = pin_func(4'(gi), cfg_q[gi]);

      assign in_val[gi] = PAD_IN_I[gi] ^ cfg_q[gi][`GPCB_BIT_POL];

      always_comb begin
        unique case (func[gi])
          GPCB_FN_KBC7: out_src[gi] = KBC_PORT_LINE_7_I;
          GPCB_FN_KBC6: out_src[gi] = KBC_PORT_LINE_6_I;
          GPCB_FN_KBC2: out_src[gi] = KBC_PORT_LINE_2_I;
          GPCB_FN_DRIVE_SEL: out_src[gi] = FLOPPY_DRIVE_SELECT_1_N_I;
          GPCB_FN_MOTOR_SEL: out_src[gi] = FLOPPY_MOTOR_SELECT_1_N_I;
          GPCB_FN_MIDI_TX: out_src[gi] = MUSIC_SERIAL_TRANSMIT_I;
          default: out_src[gi] = GPIO_OUT_I[gi];
        endcase
      end

      assign drv_val[gi] = out_src[gi] ^ cfg_q[gi][`GPCB_BIT_POL];

      assign drv_en[gi] = ~cfg_q[gi][`GPCB_BIT_DIR] & ~func_is_input(func[gi]);

      assign pad_oe_d[gi] = drv_en[gi] & (~cfg_q[gi][`GPCB_BIT_OTYPE] | ~drv_val[gi]);
      assign pad_out_d[gi] = drv_val[gi] & ~cfg_q[gi][`GPCB_BIT_OTYPE];
    end
  endgenerate

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pad_out_q <= '0;
    end else begin
      pad_out_q <= pad_out_d;
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pad_oe_q <= '0;
    end else begin
      pad_oe_q <= pad_oe_d;
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      gpio_in_q <= '0;
    end else begin
      gpio_in_q <= in_val;
    end
  end

  assign PAD_OUT_O = pad_out_q;
  assign PAD_OE_O = pad_oe_q;
  assign GPIO_IN_O = gpio_in_q;

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      stick_x_q <= 1'b0;
    end else begin
      stick_x_q <= (func[0] == GPCB_FN_STICK_X) & in_val[0];
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      stick_y_q <= 1'b0;
    end else begin
      stick_y_q <= (func[1] == GPCB_FN_STICK_Y) & in_val[1];
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      kbc7_q <= 1'b1;
    end else begin
      kbc7_q <= (func[2] == GPCB_FN_KBC7) ? in_val[2] : 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      kbc6_q <= 1'b1;
    end else begin
      kbc6_q <= (func[3] == GPCB_FN_KBC6) ? in_val[3] : 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      kbc2_q <= 1'b1;
    end else begin
      kbc2_q <= (func[4] == GPCB_FN_KBC2) ? in_val[4] : 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      midi_rx_q <= 1'b1;
    end else begin
      midi_rx_q <= (func[6] == GPCB_FN_MIDI_RX) ? in_val[6] : 1'b1;
    end
  end

  assign STICK2_X_AXIS_TIMING_O = stick_x_q;
  assign STICK2_Y_AXIS_TIMING_O = stick_y_q;
  assign KBC_PORT_LINE_7_O = kbc7_q;
  assign KBC_PORT_LINE_6_O = kbc6_q;
  assign KBC_PORT_LINE_2_O = kbc2_q;
  assign MUSIC_SERIAL_RECEIVE_O = midi_rx_q;

  // Either-edge interrupt inputs on pins 2.1 and 2.2.
  assign edge_in = {in_val[4], in_val[3]};
  assign edge_sel = {func[4] == GPCB_FN_EDGE1, func[3] == GPCB_FN_EDGE0};

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      edge_lvl_q <= '0;
    end else begin
      edge_lvl_q <= edge_in & edge_sel;
    end
  end

  // A newly selected input is armed one cycle late so selection itself is no edge.
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      edge_armed_q <= '0;
    end else begin
      edge_armed_q <= edge_sel;
    end
  end

  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      edge_evt_q <= '0;
    end else begin
      edge_evt_q <= edge_sel & edge_armed_q & ((edge_in & edge_sel) ^ edge_lvl_q);
    end
  end

  assign EDGE_LEVEL_O = edge_lvl_q;
  assign EDGE_EVENT_O = edge_evt_q;

endmodule // gpcb_top

/* test_gpio_pin_config_bank.sv */
/*
  Testbench of the pin configuration bank: APB tasks and directed scenarios.
  Assumes gpcb_top with a pad model on its pins.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module test_gpio_pin_config_bank;
  logic CLOCK_I = 1'b0, NRST_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [7:0] PADDR_I = 8'h00, GPIO_OUT_I = 8'h20, ext = 8'hFF;
  logic [7:0] PAD_IN_I, PAD_OUT_O, PAD_OE_O, GPIO_IN_O;
  logic [31:0] PWDATA_I = 32'h00000000, PRDATA_O, rd;
  logic [3:0] PSTRB_I = 4'hF;
  logic KBC_PORT_LINE_7_I = 1'b1, KBC_PORT_LINE_6_I = 1'b1, KBC_PORT_LINE_2_I = 1'b1;
  logic FLOPPY_DRIVE_SELECT_1_N_I = 1'b1, FLOPPY_MOTOR_SELECT_1_N_I = 1'b1;
  logic MUSIC_SERIAL_TRANSMIT_I = 1'b1, PREADY_O, PSLVERR_O, err, ev;
  logic KBC_PORT_LINE_7_O, KBC_PORT_LINE_6_O, KBC_PORT_LINE_2_O, MUSIC_SERIAL_RECEIVE_O;
  logic STICK2_X_AXIS_TIMING_O, STICK2_Y_AXIS_TIMING_O;
  logic [1:0] EDGE_EVENT_O, EDGE_LEVEL_O;
  int err_count = 0;
  int total_checks = 0;
  logic [7:0] adr [8] = '{8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hBC, 8'hC0, 8'hC4};
  logic [7:0] msk [8] = '{8'h87, 8'h87, 8'h87, 8'h8F, 8'h8F, 8'h83, 8'h87, 8'h87};
  gpcb_top dut (.*);
  gpcb_pad_model u_pads (.oe_i(PAD_OE_O), .out_i(PAD_OUT_O), .ext_i(ext), .pad_o(PAD_IN_I));
  initial begin
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge CLOCK_I);
    PSEL_I <= 1'b1;
    PADDR_I <= a;
    PWRITE_I <= w;
    PWDATA_I <= {24'h000000, d};
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do begin
      @(posedge CLOCK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 20);
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
  endtask
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
    repeat (2) @(posedge CLOCK_I);
    @(negedge CLOCK_I);
  endtask
  initial begin
    repeat (3) @(posedge CLOCK_I);
    NRST_I <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(adr[i], 1'b0, 8'h00);
      `CHK("reset", 32'h00000001, rd)
      apb(adr[i], 1'b1, 8'hFF);
      apb(adr[i], 1'b0, 8'h00);
      `CHK("mask", {24'h000000, msk[i]}, rd)
    end
    apb(8'hB8, 1'b1, 8'hFF);
    apb(8'hB8, 1'b0, 8'h00);
    `CHK("rsvd", 32'h00000000, rd)
    `CHK("rsvd_err", 1'b0, err)
    apb(8'h10, 1'b0, 8'h00);
    `CHK("unmapped_err", 1'b1, err)
    cfg(8'hBC, 8'h00);
    `CHK("pp_oe", 1'b1, PAD_OE_O[5])
    `CHK("pp_out", 1'b1, PAD_OUT_O[5])
    cfg(8'hBC, 8'h02);
    `CHK("pol_out", 1'b0, PAD_OUT_O[5])
    cfg(8'hBC, 8'h80);
    `CHK("od_out", 1'b0, PAD_OUT_O[5])
    cfg(8'hBC, 8'h03);
    `CHK("in_oe", 1'b0, PAD_OE_O[5])
    `CHK("in_pol", 1'b0, GPIO_IN_O[5])
    cfg(8'hBC, 8'h04);
    `CHK("no_alt", 1'b1, PAD_OUT_O[5])
    cfg(8'hA4, 8'h05);
    `CHK("stick_x", 1'b1, STICK2_X_AXIS_TIMING_O)
    cfg(8'hA8, 8'h05);
    `CHK("stick_y", 1'b1, STICK2_Y_AXIS_TIMING_O)
    cfg(8'hAC, 8'h07);
    `CHK("kbc7", 1'b0, KBC_PORT_LINE_7_O)
    cfg(8'hB0, 8'h07);
    `CHK("kbc6", 1'b0, KBC_PORT_LINE_6_O)
    cfg(8'hB4, 8'h07);
    `CHK("kbc2", 1'b0, KBC_PORT_LINE_2_O)
    cfg(8'hC0, 8'h07);
    `CHK("midi_rx", 1'b0, MUSIC_SERIAL_RECEIVE_O)
    cfg(8'hB0, 8'h0C);
    `CHK("drive_sel", 1'b1, PAD_OUT_O[3])
    cfg(8'hB4, 8'h0C);
    `CHK("motor_sel", 1'b1, PAD_OUT_O[4])
    cfg(8'hC4, 8'h04);
    `CHK("midi_tx", 1'b1, PAD_OUT_O[7])
    cfg(8'hB4, 8'h09);
    `CHK("edge1_lvl", 1'b1, EDGE_LEVEL_O[1])
    cfg(8'hB0, 8'h09);
    @(posedge CLOCK_I);
    ext <= 8'hF7;
    ev = 1'b0;
    repeat (4) begin
      @(negedge CLOCK_I);
      ev = ev | EDGE_EVENT_O[0];
    end
    `CHK("edge0_event", 1'b1, ev)
    @(posedge CLOCK_I);
    ext <= 8'hE7;
    ev = 1'b0;
    repeat (4) begin
      @(negedge CLOCK_I);
      ev = ev | EDGE_EVENT_O[1];
    end
    `CHK("edge1_event", 1'b1, ev)
    `CHK("edge1_low", 1'b0, EDGE_LEVEL_O[1])
    end_of_test();
  end
endmodule // test_gpio_pin_config_bank
bind gpcb_top gpcb_monitor u_mon (.*);
